// ---- hdl/lpcmx_pkg.sv ----
// Purpose: shared constants and carriers for the lpc and mux host port
// Assumes: one clock, lpc pins sampled on i_clk
// Notes: nibble codes and cycle counts of the lpc frame
package lpcmx_pkg;
  localparam logic [3:0] LPCMX_START = 4'h0;
  localparam logic [1:0] LPCMX_CT_HI = 2'h1;
  localparam logic [3:0] LPCMX_TAR = 4'hf;
  localparam logic [3:0] LPCMX_SHORT_WAIT_SYNC = 4'h5;
  localparam logic [3:0] LPCMX_READY_SYNC = 4'h0;
  localparam int LPCMX_ADDR_NIBBLES = 8;
  localparam int LPCMX_WAIT_CLKS = 2;
  localparam int LPCMX_FIFO_DEPTH = 16;
  localparam int LPCMX_MUX_AW = 11;

  // one request handed to the command side
  typedef struct packed {
    logic        wr;
    logic        from_mux;
    logic [31:0] addr;
    logic [7:0]  data;
  } lpcmx_req_t;

  localparam int LPCMX_REQ_W = $bits(lpcmx_req_t);
endpackage

// ---- hdl/lpcmx_fifo.sv ----
// Purpose: request fifo between the host ports and the command side
// Assumes: single clock, synchronous to i_clk
// Notes: first word fall through, honest full and empty
`timescale 1ns/10ps
`default_nettype none
module lpcmx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin
    $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  assign o_in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/lpcmx_host_port.sv ----
// Purpose: lpc target and address-mux programmer front end of a flash
// Assumes: lpc and mux pins synchronous to i_clk; read data from array side
// Notes: requests queue in a fifo; a full fifo drops the new request
`timescale 1ns/10ps
`default_nettype none
module lpcmx_host_port
  import lpcmx_pkg::*;
#(
  parameter int FIFO_DEPTH = LPCMX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_interface_reset_n,
  // lpc pins
  input wire logic i_lframe_n,
  input wire logic [3:0] i_lad,
  output logic [3:0] o_lad,
  output logic o_lad_oe,
  // mux programmer pins
  input wire logic i_mux_mode,
  input wire logic [LPCMX_MUX_AW-1:0] i_mux_address_inputs,
  input wire logic i_row_col_select,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [7:0] i_byte_io_lines,
  output logic [7:0] o_byte_io_lines,
  output logic o_byte_io_oe,
  // command side
  output logic o_req_valid,
  output lpcmx_req_t o_req,
  input wire logic i_req_ready,
  input wire logic [7:0] i_rd_data,
  output logic [31:0] o_rd_addr,
  output logic o_protect_enable,
  output logic o_security_enable,
  output logic o_abort_pe
);
  if (FIFO_DEPTH < 2)
  begin
    $error("fifo depth too small");
  end

  // ==========================================================
  // lpc state machine
  typedef enum logic [11:0] {
    S_IDLE  = 12'h001,
    S_TYPE  = 12'h002,
    S_ADDR  = 12'h004,
    S_WDATA = 12'h008,
    S_TAR1  = 12'h010,
    S_TAR2  = 12'h020,
    S_WAIT  = 12'h040,
    S_READY_SYNC = 12'h080,
    S_RDATA = 12'h100,
    S_SHORT_WAIT_SYNC = 12'h200,
    S_TARD  = 12'h400,
    S_DROP  = 12'h800
  } lpcmx_state_t;

  lpcmx_state_t state_reg;
  logic wr_reg;
  logic [2:0] cnt_reg;
  logic [31:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic in_reset;
  logic abort;
  logic lpc_push;
  logic mux_push;
  logic fifo_ready;
  logic push_valid;
  lpcmx_req_t push_req;
  lpcmx_req_t lpc_req;
  lpcmx_req_t mux_req;

  assign in_reset = !i_interface_reset_n;
  // frame low outside the start phase abandons the cycle
  assign abort = !i_lframe_n && (state_reg != S_IDLE) && (state_reg != S_TYPE);

  function automatic logic [31:0] shift_nib(input logic [31:0] a, input logic [3:0] n);
    shift_nib = {a[27:0], n};
  endfunction

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg <= S_IDLE;
      wr_reg <= 1'b0;
      cnt_reg <= 3'h0;
      addr_reg <= 32'h0;
      wdata_reg <= 8'h0;
    end
    else if (in_reset)
      state_reg <= S_IDLE;
    else if (abort)
    begin
      // a start nibble seen while aborting is taken at once, going straight to type
      state_reg <= (i_lad == LPCMX_START) ? S_TYPE : S_IDLE;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          if (!i_lframe_n && i_lad == LPCMX_START)
            state_reg <= S_TYPE;
        end
        S_TYPE:
        begin
          if (!i_lframe_n)
            state_reg <= (i_lad == LPCMX_START) ? S_TYPE : S_IDLE;
          else if (i_lad[3:2] == LPCMX_CT_HI && (i_lad[1] || !i_lad[0]))
          begin
            // read needs bit 0 zero, write ignores it
            wr_reg <= i_lad[1];
            cnt_reg <= 3'h0;
            state_reg <= S_ADDR;
          end
          else
            state_reg <= S_IDLE;
        end
        S_ADDR:
        begin
          addr_reg <= shift_nib(addr_reg, i_lad);
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(LPCMX_ADDR_NIBBLES - 1))
          begin
            cnt_reg <= 3'h0;
            state_reg <= wr_reg ? S_WDATA : S_TAR1;
          end
        end
        S_WDATA:
        begin
          // low nibble first
          if (cnt_reg == 3'h0)
          begin
            wdata_reg[3:0] <= i_lad;
            cnt_reg <= 3'h1;
          end
          else
          begin
            wdata_reg[7:4] <= i_lad;
            cnt_reg <= 3'h0;
            state_reg <= S_TAR1;
          end
        end
        // host drives 1111 here; nothing checked
        S_TAR1:
          state_reg <= S_TAR2;
        S_TAR2:
          state_reg <= wr_reg ? S_SHORT_WAIT_SYNC : S_WAIT;
        S_WAIT:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'(LPCMX_WAIT_CLKS - 1))
          begin
            cnt_reg <= 3'h0;
            state_reg <= S_READY_SYNC;
          end
        end
        S_READY_SYNC:
          state_reg <= S_RDATA;
        S_RDATA:
        begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == 3'h1)
          begin
            cnt_reg <= 3'h0;
            state_reg <= S_TARD;
          end
        end
        S_SHORT_WAIT_SYNC:
          state_reg <= S_TARD;
        S_TARD:
          state_reg <= S_DROP;
        S_DROP:
          state_reg <= S_IDLE;
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data capture for the lpc path

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rdata_reg <= 8'h0;
    else if (state_reg == S_TAR2)
      rdata_reg <= i_rd_data;
  end

  // ==========================================================
  // lad drive
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_lad <= LPCMX_TAR;
      o_lad_oe <= 1'b0;
    end
    else if (in_reset || abort)
    begin
      o_lad <= LPCMX_TAR;
      o_lad_oe <= 1'b0;
    end
    else
    begin
      o_lad_oe <= 1'b0;
      o_lad <= LPCMX_TAR;
      case (state_reg)
        S_TAR2:
        begin
          o_lad_oe <= 1'b1;
          o_lad <= wr_reg ? LPCMX_READY_SYNC : LPCMX_SHORT_WAIT_SYNC;
        end
        S_WAIT:
        begin
          o_lad_oe <= 1'b1;
          o_lad <= (cnt_reg == 3'(LPCMX_WAIT_CLKS - 1)) ? LPCMX_READY_SYNC
                                                         : LPCMX_SHORT_WAIT_SYNC;
        end
        S_READY_SYNC:
        begin
          o_lad_oe <= 1'b1;
          o_lad <= rdata_reg[3:0];
        end
        S_RDATA:
        begin
          o_lad_oe <= 1'b1;
          o_lad <= (cnt_reg == 3'h0) ? rdata_reg[7:4] : LPCMX_TAR;
        end
        S_SHORT_WAIT_SYNC:
        begin
          o_lad_oe <= 1'b1;
          o_lad <= LPCMX_TAR;
        end
        default:
        begin
          o_lad_oe <= 1'b0;
          o_lad <= LPCMX_TAR;
        end
      endcase
    end
  end

  // ==========================================================
  // mux programmer port
  logic [LPCMX_MUX_AW-1:0] row_reg;
  logic [LPCMX_MUX_AW-1:0] col_reg;
  logic rcs_d_reg;
  logic we_n_d_reg;
  logic mux_active;
  logic [31:0] mux_addr;

  assign mux_active = i_mux_mode && i_interface_reset_n;
  assign mux_addr = {10'h0, row_reg, col_reg};
  // array address follows the port in use
  assign o_rd_addr = i_mux_mode ? mux_addr : addr_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      row_reg <= '0;
      col_reg <= '0;
      rcs_d_reg <= 1'b0;
      we_n_d_reg <= 1'b1;
    end
    else
    begin
      rcs_d_reg <= i_row_col_select;
      we_n_d_reg <= i_we_n;
      // row on select falling, column on select rising
      if (mux_active && rcs_d_reg && !i_row_col_select)
        row_reg <= i_mux_address_inputs;
      if (mux_active && !rcs_d_reg && i_row_col_select)
        col_reg <= i_mux_address_inputs;
    end
  end

  // write taken on we rising with oe and reset high
  assign mux_push = mux_active && i_oe_n && !we_n_d_reg && i_we_n;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_byte_io_lines <= 8'h0;
      o_byte_io_oe <= 1'b0;
    end
    else
    begin
      o_byte_io_lines <= i_rd_data;
      o_byte_io_oe <= mux_active && !i_oe_n && i_we_n;
    end
  end

  // mux port lifts protection and hides security
  assign o_protect_enable = !i_mux_mode;
  assign o_security_enable = !i_mux_mode;
  // abort of a running program or erase
  assign o_abort_pe = in_reset;

  // ==========================================================
  // request queue
  // issued once both data nibbles are in; a later abort cannot cancel it
  assign lpc_push = (state_reg == S_TAR1) && wr_reg && !in_reset;
  assign lpc_req = '{wr: 1'b1, from_mux: 1'b0, addr: addr_reg, data: wdata_reg};
  assign mux_req = '{wr: 1'b1, from_mux: 1'b1,
                     addr: mux_addr, data: i_byte_io_lines};
  assign push_valid = lpc_push || mux_push;
  assign push_req = lpc_push ? lpc_req : mux_req;

  lpcmx_fifo #(
    .WIDTH(LPCMX_REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(push_valid),
    .i_in_data(push_req),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_req_valid),
    .o_out_data(o_req),
    .i_out_ready(i_req_ready)
  );

  // fifo ready gates nothing further: a write reaches sync even with the fifo full
  logic unused_ready;
  assign unused_ready = fifo_ready;
endmodule
`default_nettype wire

// ---- testbench/lpcmx_host_port_sva.sv ----
// Purpose: port checks of the lpc and mux host port
// Assumes: one clock domain, lpc pins sampled on i_clk
// Notes: attached by bind
`timescale 1ns/10ps
`default_nettype none
module lpcmx_host_port_sva
  import lpcmx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_interface_reset_n,
  // watched pins
  input wire logic i_lframe_n,
  input wire logic [3:0] i_lad,
  input wire logic [3:0] o_lad,
  input wire logic o_lad_oe,
  input wire logic i_mux_mode,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic o_byte_io_oe,
  input wire logic o_protect_enable,
  input wire logic o_security_enable,
  input wire logic o_abort_pe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // =====================
  // lpc frame
  property p_rd_seq;
    $rose(o_lad_oe) && o_lad == LPCMX_SHORT_WAIT_SYNC |-> ##1 o_lad == LPCMX_SHORT_WAIT_SYNC
      ##1 o_lad == LPCMX_READY_SYNC ##3 o_lad == LPCMX_TAR ##1 !o_lad_oe;
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("read sync order wrong");
  property p_wr_seq;
    $rose(o_lad_oe) && o_lad == 4'h0 && i_lframe_n |=> o_lad == LPCMX_TAR && o_lad_oe ##1 !o_lad_oe;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write sync end wrong");
  property p_take;
    $rose(o_lad_oe) |-> $past(i_lad) == LPCMX_TAR && $past(i_lframe_n);
  endproperty
  a_take: assert property (p_take) else $error("bus taken early");
  property p_abort;
    o_lad_oe && !i_lframe_n |=> !o_lad_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("abort kept driving");
  // =====================
  // mux port and reset
  property p_byte_on;
    !i_oe_n && i_we_n && i_interface_reset_n && i_mux_mode |=> o_byte_io_oe;
  endproperty
  a_byte_on: assert property (p_byte_on) else $error("byte read not driven");
  property p_byte_off;
    i_oe_n |=> !o_byte_io_oe;
  endproperty
  a_byte_off: assert property (p_byte_off) else $error("byte lines driven");
  property p_rst_float;
    !i_interface_reset_n |=> !o_lad_oe && !o_byte_io_oe;
  endproperty
  a_rst_float: assert property (p_rst_float) else $error("driving in reset");
  property p_abort_pe;
    !i_interface_reset_n |-> o_abort_pe;
  endproperty
  a_abort_pe: assert property (p_abort_pe) else $error("no abort in reset");
  property p_protect;
    o_protect_enable == !i_mux_mode;
  endproperty
  a_protect: assert property (p_protect) else $error("protect on in mux mode");
  property p_security;
    o_security_enable == !i_mux_mode;
  endproperty
  a_security: assert property (p_security) else $error("security in mux mode");
  c_read: cover property ($rose(o_lad_oe) && o_lad == LPCMX_SHORT_WAIT_SYNC);
  c_write: cover property ($rose(o_lad_oe) && o_lad == 4'h0);
  c_abort: cover property (o_lad_oe && !i_lframe_n);
endmodule
bind lpcmx_host_port lpcmx_host_port_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_interface_reset_n(i_interface_reset_n), .i_lframe_n(i_lframe_n), .i_lad(i_lad),
  .o_lad(o_lad), .o_lad_oe(o_lad_oe), .i_mux_mode(i_mux_mode), .i_oe_n(i_oe_n),
  .i_we_n(i_we_n), .o_byte_io_oe(o_byte_io_oe), .o_protect_enable(o_protect_enable),
  .o_security_enable(o_security_enable), .o_abort_pe(o_abort_pe));
`default_nettype wire

// ---- testbench/lpcmx_lpc_host.sv ----
// Purpose: lpc host model
// Assumes: lad has pull-ups, a released bus reads 1111
// Notes: log_q holds the bus level of each of 19 cycles
`timescale 1ns/10ps
`default_nettype none
module lpcmx_lpc_host (
  // clock
  input wire logic i_clk,
  // lpc pins
  output logic o_lframe_n,
  output logic [3:0] o_lad,
  input wire logic [3:0] i_dev_lad,
  input wire logic i_dev_oe
);
  logic host_oe = 1'b0;
  logic [3:0] host_val = 4'hf;
  logic [3:0] log_q [0:18];
  initial o_lframe_n = 1'b1;
  assign o_lad = host_oe ? host_val : (i_dev_oe ? i_dev_lad : 4'hf);
  task automatic cycle(input logic [3:0] ty, input logic [31:0] a, input logic [7:0] d,
    input int ab);
    int last;
    last = ty[1] ? 12 : 10;
    for (int i = 0; i < 19; i++)
    begin
      @(negedge i_clk);
      o_lframe_n <= !(i == 0 || i == ab);
      host_oe <= i <= last && i < ab;
      // start, type, address msb first, write data low first, then 1111
      host_val <= i == 0 ? 4'h0 : i == 1 ? ty : i < 10 ? 4'(a >> (4 * (9 - i))) :
        ty[1] && i == 10 ? d[3:0] : ty[1] && i == 11 ? d[7:4] : 4'hf;
      #9;
      log_q[i] = o_lad;
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/lpcmx_host_port_tb.sv ----
// Purpose: self-checking bench of the lpc and mux host port
// Assumes: inputs driven on the falling edge
// Notes: array data is the address low byte xor 5a
`timescale 1ns/10ps
`default_nettype none
module lpcmx_host_port_tb
  import lpcmx_pkg::*;
;
  logic i_clk, i_sys_rst, rst_n, lframe_n, lad_oe, mode, rcs, oe_n, we_n, req_valid, req_ready;
  logic byte_oe, prot, sec, abort_pe;
  logic [3:0] lad_in, lad_out;
  logic [10:0] maddr;
  logic [7:0] byte_drv, byte_out, byte_bus, rd_data;
  logic [31:0] rd_addr;
  lpcmx_req_t req;
  int err_count = 0;
  int tests_run = 0;
  assign byte_bus = byte_oe ? byte_out : byte_drv;
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  lpcmx_host_port u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_interface_reset_n(rst_n),
    .i_lframe_n(lframe_n), .i_lad(lad_in), .o_lad(lad_out), .o_lad_oe(lad_oe),
    .i_mux_mode(mode), .i_mux_address_inputs(maddr), .i_row_col_select(rcs), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_byte_io_lines(byte_bus), .o_byte_io_lines(byte_out),
    .o_byte_io_oe(byte_oe), .o_req_valid(req_valid), .o_req(req), .i_req_ready(req_ready),
    .i_rd_data(rd_data), .o_rd_addr(rd_addr), .o_protect_enable(prot),
    .o_security_enable(sec), .o_abort_pe(abort_pe));
  lpcmx_lpc_host u_host (.i_clk(i_clk), .o_lframe_n(lframe_n), .o_lad(lad_in),
    .i_dev_lad(lad_out), .i_dev_oe(lad_oe));
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // =====================
  // checking helpers
  task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pop_chk(input logic [41:0] exp);
    for (int n = 0; n < 20 && req_valid !== 1'b1; n++)
      @(negedge i_clk);
    chk(req, exp);
    req_ready <= 1'b1;
    @(negedge i_clk);
    req_ready <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic drain;
    @(negedge i_clk);
    req_ready <= 1'b1;
    repeat (20) @(negedge i_clk);
    req_ready <= 1'b0;
  endtask
  // =====================
  // scenarios
  task automatic lpc_case(input logic [3:0] ty, input logic [31:0] a, input logic [7:0] d,
    input int ab);
    logic [3:0] e [0:18];
    logic [7:0] r;
    r = a[7:0] ^ 8'h5a;
    drain();
    u_host.cycle(ty, a, d, ab);
    @(negedge i_clk);
    for (int i = 0; i < 19; i++)
      e[i] = i == 0 ? 4'h0 : i == 1 ? ty : i < 10 ? 4'(a >> (4 * (9 - i))) : 4'hf;
    if (ty == 4'h4)
      {e[12], e[13], e[14], e[15], e[16]} = {8'h55, 4'h0, r[3:0], r[7:4]};
    if (ty[3:1] == 3'b011)
      {e[10], e[11], e[14]} = {d[3:0], d[7:4], 4'h0};
    for (int i = 0; i < 19; i++)
    begin
      if (i > ab || (i == ab && i <= (ty[1] ? 12 : 10)))
        e[i] = 4'hf;
      chk(u_host.log_q[i], e[i]);
    end
    if (ty[3:1] == 3'b011)
      pop_chk({1'b1, 1'b0, a, d});
    else if (ty != 4'h4)
      chk(req_valid, 1'b0);
    $display("done lpc type %h abort %0d", ty, ab);
  endtask
  task automatic mux_wr(input logic [10:0] row, input logic [10:0] col, input logic [7:0] d);
    @(negedge i_clk);
    maddr <= row;
    rcs <= 1'b0;
    @(negedge i_clk);
    maddr <= col;
    rcs <= 1'b1;
    byte_drv <= d;
    @(negedge i_clk);
    we_n <= 1'b0;
    @(negedge i_clk);
    we_n <= 1'b1;
    @(negedge i_clk);
  endtask
  task automatic mux_case;
    mode <= 1'b1;
    drain();
    chk({prot, sec}, 2'b00);
    for (int k = 0; k < 17; k++)
      mux_wr(11'h0, 11'(k), 8'(k));
    for (int k = 0; k < 16; k++)
      pop_chk({1'b1, 1'b1, 32'(k), 8'(k)});
    chk(req_valid, 1'b0);
    mux_wr(11'h3, 11'h2c, 8'h0);
    oe_n <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk({byte_oe, byte_out}, {1'b1, 8'h2c ^ 8'h5a});
    oe_n <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk(byte_oe, 1'b0);
    oe_n <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(negedge i_clk);
    chk({byte_oe, lad_oe, abort_pe}, 3'b001);
    {rst_n, oe_n, mode} <= 3'b110;
    drain();
    $display("done mux port");
  endtask
  initial
  begin
    {i_sys_rst, rst_n, mode, rcs, oe_n, we_n, req_ready} = 7'b1101110;
    maddr = 11'h0;
    byte_drv = 8'h0;
    repeat (10) @(negedge i_clk);
    i_sys_rst <= 1'b0;
    lpc_case(4'h4, 32'hffbc1234, 8'h0, 99);
    lpc_case(4'h6, 32'hffc00005, 8'ha7, 99);
    lpc_case(4'h7, 32'hff800a61, 8'h3c, 14);
    lpc_case(4'h4, 32'hffbc0077, 8'h0, 5);
    lpc_case(4'h8, 32'hffbc0001, 8'h0, 99);
    mux_case();
    lpc_case(4'h4, 32'hffbfffee, 8'h0, 99);
    report_and_stop();
  end
  initial
  begin
    #200us;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
